// *** mode_sync_pin_decoder_tb_top.sv ***
// Purpose: self-checking bench for the mode/sync pin decoder
// Assumes: settling time shortened to 200 cycles; default switch period 100 cycles
// Notes: pin comes from the controller model, status inputs from the bench
`timescale 1ns/1ps
module mode_sync_pin_decoder_tb_top;
    // ==================================================================
    // settings and signals
    localparam int MODE_CYC = 200;
    localparam int DEF_PER = 100;
    localparam int SETTLE_WAIT = MODE_CYC + 10;
    logic core_clk;
    logic nrst;
    logic [1:0] levelClass;
    logic dropoutFoldback;
    logic lowFreqCond;
    logic modeSyncPin;
    logic modeFpwm;
    logic modeSync;
    logic diodeEmuEn;
    logic spreadEn;
    logic pulseCtrl;
    logic freqLocked;
    logic phaseAligned;
    logic swClkPulse;
    int errorCnt = 0;
    int nCompared = 0;
    int gapCnt = 0;
    int lastGap = 0;
    int transGap = 0;
    logic sawLock = 1'b0;

    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ==================================================================
    // instances
    msd_mode_sync_decoder #(.MODE_CYC(MODE_CYC), .DEF_PER(DEF_PER)) uut (
        .core_clk(core_clk), .nrst(nrst), .modeSyncPin(modeSyncPin),
        .levelClass(levelClass), .dropoutFoldback(dropoutFoldback),
        .lowFreqCond(lowFreqCond), .modeFpwm(modeFpwm), .modeSync(modeSync),
        .diodeEmuEn(diodeEmuEn), .spreadEn(spreadEn), .pulseCtrl(pulseCtrl),
        .freqLocked(freqLocked), .phaseAligned(phaseAligned), .swClkPulse(swClkPulse)
    );
    msd_ctrl_model ctrl (.modeSyncPin(modeSyncPin));

    // switching period monitor; the first gap after lock is the transition cycle
    // sampled on the falling edge, where the registered outputs have settled
    always @(negedge core_clk) begin
        gapCnt++;
        if (swClkPulse === 1'b1) begin
            lastGap = gapCnt;
            if (freqLocked === 1'b1 && !sawLock) begin
                transGap = gapCnt;
                sawLock = 1'b1;
            end
            gapCnt = 0;
        end
    end

    // ==================================================================
    // helpers
    task automatic chk(input logic got, input logic exp, input string what);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: %s is %b", $time, what, got);
        end
    endtask : chk

    // sample one step after the edge so register updates have landed
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    task automatic do_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
    endtask : do_reset

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // ==================================================================
    // scenarios
    task automatic test_reset();
        do_reset();
        wait_cyc(2);
        chk(pulseCtrl, 1'b0, "pulseCtrl");
        chk(diodeEmuEn, 1'b1, "diodeEmuEn");
        chk(modeSync, 1'b0, "modeSync");
        chk(freqLocked, 1'b0, "freqLocked");
        $display("test reset done");
    endtask : test_reset

    // GND, VCC and VIN level classes mapped after the settling time
    task automatic test_level();
        logic [1:0] cls [3] = '{2'h0, 2'h1, 2'h3};
        logic expFpwm [3] = '{1'b0, 1'b1, 1'b1};
        logic expSs [3] = '{1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            levelClass <= cls[i];
            wait_cyc(SETTLE_WAIT);
            chk(modeFpwm, expFpwm[i], "level modeFpwm");
            chk(spreadEn, expSs[i], "level spreadEn");
            chk(diodeEmuEn, !expFpwm[i], "level diodeEmuEn");
        end
        $display("test level done");
    endtask : test_level

    // three periods are not enough, four are
    task automatic test_entry();
        ctrl.sync_burst(4);
        wait_cyc(300);
        chk(pulseCtrl, 1'b0, "pulseCtrl early");
        chk(modeSync, 1'b0, "modeSync level ctrl");
        chk(freqLocked, 1'b0, "freqLocked level ctrl");
        ctrl.sync_burst(10);
        wait_cyc(2);
        chk(pulseCtrl, 1'b1, "pulseCtrl");
        chk(modeSync, 1'b1, "modeSync");
        chk(diodeEmuEn, 1'b0, "diodeEmuEn sync");
        chk(spreadEn, 1'b1, "spreadEn first edge");
        chk(freqLocked, 1'b0, "freqLocked early");
        $display("test entry done");
    endtask : test_entry

    // lock held off by a slow clock, then taken with phase alignment
    task automatic test_lock();
        @(posedge core_clk);
        lowFreqCond <= 1'b1;
        ctrl.sync_burst(2050);
        wait_cyc(4);
        chk(freqLocked, 1'b0, "freqLocked held");
        chk(spreadEn, 1'b1, "spreadEn before lock");
        @(posedge core_clk);
        lowFreqCond <= 1'b0;
        ctrl.sync_burst(120);
        chk(freqLocked, 1'b1, "freqLocked");
        chk(spreadEn, 1'b0, "spreadEn locked");
        chk(phaseAligned, 1'b1, "phaseAligned");
        chk(lastGap == 8, 1'b1, "sync period");
        chk(transGap >= 8 && transGap <= DEF_PER, 1'b1, "transition cycle");
        $display("test lock done");
    endtask : test_lock

    // leave sync by a steady level, then a delayed mode change and dropout
    task automatic test_leave();
        ctrl.set_level(1'b1);
        wait_cyc(SETTLE_WAIT);
        chk(modeSync, 1'b0, "modeSync left");
        chk(freqLocked, 1'b0, "freqLocked left");
        chk(spreadEn, 1'b1, "spreadEn left");
        chk(modeFpwm, 1'b1, "modeFpwm high");
        chk(pulseCtrl, 1'b1, "pulseCtrl sticky");
        ctrl.set_level(1'b0);
        wait_cyc(MODE_CYC / 2);
        chk(modeFpwm, 1'b1, "modeFpwm before settle");
        wait_cyc(SETTLE_WAIT - MODE_CYC / 2);
        chk(modeFpwm, 1'b0, "modeFpwm low");
        chk(diodeEmuEn, 1'b1, "diodeEmuEn auto");
        chk(spreadEn, 1'b1, "spreadEn auto");
        @(posedge core_clk);
        dropoutFoldback <= 1'b1;
        wait_cyc(5);
        chk(spreadEn, 1'b0, "spreadEn foldback");
        @(posedge core_clk);
        dropoutFoldback <= 1'b0;
        wait_cyc(5);
        chk(spreadEn, 1'b1, "spreadEn after foldback");
        $display("test leave done");
    endtask : test_leave

    // double pulse ending high and ending low
    task automatic test_double();
        ctrl.double_pulse(1'b1);
        wait_cyc(SETTLE_WAIT);
        chk(modeFpwm, 1'b1, "dp modeFpwm");
        chk(spreadEn, 1'b0, "dp spreadEn high");
        ctrl.set_level(1'b0);
        wait_cyc(SETTLE_WAIT);
        chk(spreadEn, 1'b1, "single edge spreadEn");
        ctrl.double_pulse(1'b0);
        wait_cyc(SETTLE_WAIT);
        chk(modeFpwm, 1'b0, "dp modeFpwm low");
        chk(spreadEn, 1'b0, "dp spreadEn low");
        chk(diodeEmuEn, 1'b1, "dp diodeEmuEn");
        $display("test double done");
    endtask : test_double

    // restart into level control with the fixed strap level
    task automatic test_strap();
        @(posedge core_clk);
        levelClass <= 2'h2;
        do_reset();
        wait_cyc(2);
        chk(pulseCtrl, 1'b0, "pulseCtrl after restart");
        wait_cyc(SETTLE_WAIT);
        chk(modeFpwm, 1'b0, "strap modeFpwm");
        chk(spreadEn, 1'b0, "strap spreadEn");
        ctrl.sync_burst(10);
        wait_cyc(4);
        chk(pulseCtrl, 1'b0, "strap pulseCtrl");
        chk(modeSync, 1'b0, "strap modeSync");
        @(posedge core_clk);
        levelClass <= 2'h1;
        wait_cyc(SETTLE_WAIT);
        chk(modeFpwm, 1'b0, "strap fixed");
        chk(diodeEmuEn, 1'b1, "strap auto");
        $display("test strap done");
    endtask : test_strap

    // ==================================================================
    // main sequence and watchdog
    initial begin
        nrst = 1'b0;
        levelClass = 2'h0;
        dropoutFoldback = 1'b0;
        lowFreqCond = 1'b0;
        test_reset();
        test_level();
        test_entry();
        test_lock();
        test_leave();
        test_double();
        test_strap();
        end_of_test();
    end

    // runs near 20k cycles; allow well beyond that before giving up
    initial begin
        repeat (60000) @(posedge core_clk);
        errorCnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end

endmodule : mode_sync_pin_decoder_tb_top

// *** msd_ctrl_model.sv ***
// Purpose: behavioural controller that drives the mode/sync pin
// Assumes: push-pull driver, so the pin is never left floating
// Notes: link period 200 ns; each call starts 7 ns late to stay off core_clk edges
`timescale 1ns/1ps
module msd_ctrl_model (
    // pin driven by the controller
    output logic modeSyncPin
);
    // ==================================================================
    // link timing
    localparam int HALF_NS = 100;

    // pin idles low until the bench asks for something
    initial begin
        modeSyncPin = 1'b0;
    end

    // ==================================================================
    // waveform tasks
    // continuous sync train, 50% duty, every pulse of valid width and period
    task automatic sync_burst(input int n);
        #7;
        repeat (n) begin
            modeSyncPin = 1'b1;
            #(HALF_NS);
            modeSyncPin = 1'b0;
            #(HALF_NS);
        end
    endtask : sync_burst

    // two rises shaped like sync pulses, then the level is left to settle
    task automatic double_pulse(input logic endHigh);
        #7;
        modeSyncPin = 1'b1;
        #(HALF_NS);
        modeSyncPin = 1'b0;
        #(HALF_NS);
        modeSyncPin = 1'b1;
        if (!endHigh) begin
            #(HALF_NS);
            modeSyncPin = 1'b0;
        end
    endtask : double_pulse

    // plain single-edge level change
    task automatic set_level(input logic v);
        #7;
        modeSyncPin = v;
    endtask : set_level

endmodule : msd_ctrl_model

// *** msd_edge_meter.sv ***
// Purpose: synchronises the mode/sync pin and measures each pulse of a train
// Assumes: pin is asynchronous to core_clk
// Notes: a period is judged valid on the rise that closes it
`timescale 1ns/1ps
module msd_edge_meter #(
    parameter int CW = msd_pkg::CNT_W,
    parameter int SW = msd_pkg::SETTLE_W,
    parameter int MODE_CYC = msd_pkg::MODE_SETTLE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pin
    input wire logic modeSyncPin,
    // measurements
    msd_meter_if.meter m
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic armed;
        logic [CW-1:0] since;
        logic [CW-1:0] high;
        logic [SW-1:0] quietCnt;
        logic riseEv;
        logic okEv;
        logic badEv;
        logic settleEv;
        logic quiet;
        logic [CW-1:0] period;
    } msd_meter_s;

    localparam logic [CW-1:0] MIN_PER = CW'(msd_pkg::SYNC_MIN_PERIOD_CYC);
    localparam logic [CW-1:0] MAX_PER = CW'(msd_pkg::SYNC_MAX_PERIOD_CYC);
    localparam logic [CW-1:0] MIN_PH = CW'(msd_pkg::SYNC_MIN_PHASE_CYC);
    localparam logic [SW-1:0] QUIET_CYC = SW'(MODE_CYC);

    msd_meter_s r_r;
    msd_meter_s r_nxt;
    logic rise;
    logic fall;
    logic [CW-1:0] perNow;

    // ==================================================================
    // edge detection and period checks; s1 feeds s2 only
    always_comb begin
        r_nxt = r_r;
        r_nxt.s1 = modeSyncPin;
        r_nxt.s2 = r_r.s1;
        r_nxt.prev = r_r.s2;
        rise = r_r.s2 & ~r_r.prev;
        fall = ~r_r.s2 & r_r.prev;
        perNow = r_r.since + 1'b1;
        r_nxt.riseEv = rise;
        r_nxt.okEv = 1'b0;
        r_nxt.badEv = 1'b0;
        r_nxt.settleEv = 1'b0;
        if (r_r.since != MAX_PER) begin
            r_nxt.since = perNow;
        end
        if (fall) begin
            r_nxt.high = perNow;
        end
        // a too-long gap breaks the train once, then disarms
        if (r_r.armed && r_r.since == MAX_PER && !rise) begin
            r_nxt.badEv = 1'b1;
            r_nxt.armed = 1'b0;
        end
        if (rise) begin
            r_nxt.since = '0;
            r_nxt.armed = 1'b1;
            if (r_r.armed) begin
                if (perNow >= MIN_PER && perNow <= MAX_PER && r_r.high >= MIN_PH
                    && (perNow - r_r.high) >= MIN_PH) begin
                    r_nxt.okEv = 1'b1;
                    r_nxt.period = perNow;
                end else begin
                    r_nxt.badEv = 1'b1;
                end
            end
        end
        // steady level timer; settle event fires once per quiet stretch
        if (rise || fall) begin
            r_nxt.quietCnt = '0;
            r_nxt.quiet = 1'b0;
        end else if (r_r.quietCnt != QUIET_CYC) begin
            r_nxt.quietCnt = r_r.quietCnt + 1'b1;
            if (r_r.quietCnt == QUIET_CYC - 1'b1) begin
                r_nxt.settleEv = 1'b1;
                r_nxt.quiet = 1'b1;
                r_nxt.armed = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign m.riseEv = r_r.riseEv;
    assign m.okEv = r_r.okEv;
    assign m.badEv = r_r.badEv;
    assign m.settleEv = r_r.settleEv;
    assign m.quiet = r_r.quiet;
    assign m.level = r_r.prev;
    assign m.period = r_r.period;

endmodule : msd_edge_meter

// *** msd_meter_if.sv ***
// Purpose: carries pulse measurements from the edge meter to the decoder
// Assumes: both ends run on core_clk
// Notes: all event signals are one-cycle pulses
`timescale 1ns/1ps
interface msd_meter_if #(parameter int CW = 16);
    logic riseEv;
    logic okEv;
    logic badEv;
    logic settleEv;
    logic quiet;
    logic level;
    logic [CW-1:0] period;

    modport meter (output riseEv, okEv, badEv, settleEv, quiet, level, period);
    modport dec (input riseEv, okEv, badEv, settleEv, quiet, level, period);
endinterface : msd_meter_if

// *** msd_mode_sync_decoder.sv ***
// Purpose: decodes the mode/sync pin into operating mode, spread spectrum and clock lock
// Assumes: pin and comparator/foldback inputs are asynchronous; core_clk is 40 MHz
// Notes: only nrst returns the pin to level-dependent control
`timescale 1ns/1ps
module msd_mode_sync_decoder #(
    parameter int MODE_CYC = msd_pkg::MODE_SETTLE_CYC,
    parameter int DEF_PER = msd_pkg::DEFAULT_SW_PERIOD_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pin and analog status
    input wire logic modeSyncPin,
    input wire logic [1:0] levelClass,
    input wire logic dropoutFoldback,
    input wire logic lowFreqCond,
    // decoded mode
    output logic modeFpwm,
    output logic modeSync,
    output logic diodeEmuEn,
    output logic spreadEn,
    output logic pulseCtrl,
    // clock locking
    output logic freqLocked,
    output logic phaseAligned,
    output logic swClkPulse
);
    localparam int CW = msd_pkg::CNT_W;
    localparam int SW = msd_pkg::SETTLE_W;
    localparam int PW = msd_pkg::PULSE_W;
    localparam logic [SW-1:0] SETTLE = SW'(MODE_CYC);
    localparam logic [CW-1:0] DEF_P = CW'(DEF_PER);

    typedef struct packed {
        logic [1:0] lvA;
        logic [1:0] lvB;
        logic drA;
        logic drB;
        logic lfA;
        logic lfB;
        logic [1:0] lvSeen;
        logic [SW-1:0] lvStable;
        logic pulseCtrl;
        logic strapFixed;
        logic [PW-1:0] okCnt;
        logic [2:0] rises;
        logic forced_pwm_mode;
        logic sync;
        logic ssReq;
        logic spread;
        logic dem;
        logic locked;
        logic trans;
        logic aligned;
        logic swPulse;
        logic [CW-1:0] osc;
        logic [CW-1:0] per;
    } msd_top_s;

    msd_top_s r_r;
    msd_top_s r_nxt;
    logic [CW:0] avgSum;

    msd_meter_if #(.CW(CW)) mIf ();

    msd_edge_meter #(.CW(CW), .SW(SW), .MODE_CYC(MODE_CYC)) uMeter (
        .core_clk(core_clk),
        .nrst(nrst),
        .modeSyncPin(modeSyncPin),
        .m(mIf.meter)
    );

    // ==================================================================
    // decode and oscillator
    always_comb begin
        r_nxt = r_r;
        r_nxt.lvA = levelClass;
        r_nxt.lvB = r_r.lvA;
        r_nxt.drA = dropoutFoldback;
        r_nxt.drB = r_r.drA;
        r_nxt.lfA = lowFreqCond;
        r_nxt.lfB = r_r.lfA;
        r_nxt.swPulse = 1'b0;
        avgSum = {1'b0, DEF_P} + {1'b0, mIf.period};
        // level class must hold a full settling time before it counts
        if (r_r.lvB != r_r.lvSeen) begin
            r_nxt.lvSeen = r_r.lvB;
            r_nxt.lvStable = '0;
        end else if (r_r.lvStable != SETTLE) begin
            r_nxt.lvStable = r_r.lvStable + 1'b1;
        end
        if (!r_r.pulseCtrl && !r_r.strapFixed && r_r.lvStable == SETTLE) begin
            case (msd_pkg::msd_level_e'(r_r.lvSeen))
                msd_pkg::LVL_GND: begin
                    r_nxt.forced_pwm_mode = 1'b0;
                    r_nxt.ssReq = 1'b1;
                end
                msd_pkg::LVL_VCC: begin
                    r_nxt.forced_pwm_mode = 1'b1;
                    r_nxt.ssReq = 1'b1;
                end
                msd_pkg::LVL_VIN: begin
                    r_nxt.forced_pwm_mode = 1'b1;
                    r_nxt.ssReq = 1'b0;
                end
                default: begin
                    r_nxt.forced_pwm_mode = 1'b0;
                    r_nxt.ssReq = 1'b0;
                    r_nxt.strapFixed = 1'b1;
                end
            endcase
        end
        // pulse trains; a strapped pin ignores all of this
        if (!r_r.strapFixed) begin
            if (mIf.riseEv && r_r.rises != 3'h7) begin
                r_nxt.rises = r_r.rises + 1'b1;
            end
            if (mIf.okEv && r_r.okCnt != msd_pkg::LOCK_PULSES) begin
                r_nxt.okCnt = r_r.okCnt + 1'b1;
                if (r_r.okCnt == msd_pkg::PULSE_CTRL_PULSES - 1'b1) begin
                    r_nxt.pulseCtrl = 1'b1;
                end
            end
            if (mIf.okEv && r_r.pulseCtrl && !r_r.locked
                && r_r.rises >= msd_pkg::DOUBLE_PULSE_RISES) begin
                r_nxt.sync = 1'b1;
                r_nxt.ssReq = 1'b1;
            end
            // lock only after the pulse count and with full frequency available
            if (r_r.sync && !r_r.locked && r_r.okCnt == msd_pkg::LOCK_PULSES
                && !r_r.lfB) begin
                r_nxt.locked = 1'b1;
                r_nxt.ssReq = 1'b0;
                r_nxt.trans = 1'b1;
                r_nxt.per = avgSum[CW:1];
            end
            if (mIf.badEv) begin
                r_nxt.okCnt = '0;
                r_nxt.locked = 1'b0;
                r_nxt.trans = 1'b0;
                r_nxt.aligned = 1'b0;
                r_nxt.per = DEF_P;
            end
            // steady level for the settling time ends any sync or double pulse
            if (mIf.settleEv) begin
                r_nxt.okCnt = '0;
                r_nxt.rises = '0;
                if (r_r.pulseCtrl) begin
                    r_nxt.forced_pwm_mode = mIf.level;
                    r_nxt.ssReq = r_r.sync || r_r.rises != msd_pkg::DOUBLE_PULSE_RISES;
                    r_nxt.sync = 1'b0;
                    r_nxt.locked = 1'b0;
                    r_nxt.trans = 1'b0;
                    r_nxt.aligned = 1'b0;
                    r_nxt.per = DEF_P;
                end
            end
        end
        // switching clock; the lock cycle keeps the running phase
        if (r_r.osc >= r_r.per - 1'b1) begin
            r_nxt.osc = '0;
            r_nxt.swPulse = 1'b1;
            if (r_r.trans) begin
                r_nxt.trans = 1'b0;
                r_nxt.per = mIf.period;
            end
        end else begin
            r_nxt.osc = r_r.osc + 1'b1;
        end
        // one step per sync rise, so alignment takes tens of cycles
        if (r_r.locked && !r_r.trans && mIf.riseEv) begin
            r_nxt.aligned = (r_r.osc == '0);
            r_nxt.per = mIf.okEv ? mIf.period : r_nxt.per;
            if (r_r.osc != '0 && r_r.osc < {1'b0, r_r.per[CW-1:1]}) begin
                r_nxt.osc = r_r.osc;
            end else if (r_r.osc != '0 && r_r.osc + 2'h2 < r_r.per) begin
                r_nxt.osc = r_r.osc + 2'h2;
            end else if (r_r.osc != '0) begin
                r_nxt.osc = r_r.osc + 2'h2 - r_r.per; // advance across the wrap
                r_nxt.swPulse = 1'b1;
            end
        end
        // spread is off in dropout foldback and while locked
        r_nxt.spread = r_nxt.ssReq && !r_r.drB && !r_nxt.locked && !r_nxt.strapFixed;
        r_nxt.dem = !(r_nxt.forced_pwm_mode || r_nxt.sync);
    end

    // state register; restart returns to level control
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r_r <= '0;
            r_r.per <= DEF_P;
            r_r.dem <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign modeFpwm = r_r.forced_pwm_mode;
    assign modeSync = r_r.sync;
    assign diodeEmuEn = r_r.dem;
    assign spreadEn = r_r.spread;
    assign pulseCtrl = r_r.pulseCtrl;
    assign freqLocked = r_r.locked;
    assign phaseAligned = r_r.aligned;
    assign swClkPulse = r_r.swPulse;

    // ==================================================================
    // checks
    property p_entry;
        @(posedge core_clk) disable iff (!nrst)
        $rose(r_r.pulseCtrl) |-> $past(mIf.okEv) && $past(r_r.okCnt) == 12'h0003;
    endproperty
    a_entry: assert property (p_entry) else $error("pulse control without fourth pulse");

    property p_sticky;
        @(posedge core_clk) disable iff (!nrst)
        r_r.pulseCtrl |=> r_r.pulseCtrl [*4];
    endproperty
    a_sticky: assert property (p_sticky) else $error("pulse control dropped");

    property p_no_lock_level;
        @(posedge core_clk) disable iff (!nrst)
        !r_r.pulseCtrl |-> !r_r.locked && !r_r.sync;
    endproperty
    a_no_lock_level: assert property (p_no_lock_level) else $error("lock in level control");

    property p_lock_ss;
        @(posedge core_clk) disable iff (!nrst)
        $rose(r_r.locked) |=> !r_r.spread;
    endproperty
    a_lock_ss: assert property (p_lock_ss) else $error("spread on while locked");

    property p_lowfreq;
        @(posedge core_clk) disable iff (!nrst)
        $rose(r_r.locked) |-> !$past(r_r.lfB) && $past(r_r.okCnt) == 12'h0800;
    endproperty
    a_lowfreq: assert property (p_lowfreq) else $error("lock while slowed");

    property p_dropout;
        @(posedge core_clk) disable iff (!nrst)
        r_r.drB |=> !r_r.spread;
    endproperty
    a_dropout: assert property (p_dropout) else $error("spread on in foldback");

    property p_sync_dem;
        @(posedge core_clk) disable iff (!nrst)
        r_r.sync |-> !r_r.dem;
    endproperty
    a_sync_dem: assert property (p_sync_dem) else $error("diode emulation in sync");

    property p_strap;
        @(posedge core_clk) disable iff (!nrst)
        r_r.strapFixed |=> !r_r.forced_pwm_mode && !r_r.spread && !r_r.pulseCtrl && r_r.strapFixed;
    endproperty
    a_strap: assert property (p_strap) else $error("strapped mode changed");

    property p_settle_leave;
        @(posedge core_clk) disable iff (!nrst)
        mIf.settleEv && r_r.pulseCtrl && !r_r.strapFixed |=>
            !r_r.sync && r_r.forced_pwm_mode == $past(mIf.level) && r_r.pulseCtrl;
    endproperty
    a_settle_leave: assert property (p_settle_leave) else $error("settle not applied");

    property p_trans;
        @(posedge core_clk) disable iff (!nrst)
        $rose(r_r.trans) |-> (r_r.per >= DEF_P || r_r.per >= mIf.period)
            && (r_r.per <= DEF_P || r_r.per <= mIf.period);
    endproperty
    a_trans: assert property (p_trans) else $error("transition cycle out of range");

    c_pulse: cover property (@(posedge core_clk) disable iff (!nrst) $rose(r_r.pulseCtrl));
    c_lock: cover property (@(posedge core_clk) disable iff (!nrst) $rose(r_r.locked));
    c_align: cover property (@(posedge core_clk) disable iff (!nrst) $rose(r_r.aligned));
    c_dbl: cover property (@(posedge core_clk) disable iff (!nrst)
        r_r.pulseCtrl && $fell(r_r.ssReq) && !r_r.locked);

endmodule : msd_mode_sync_decoder

// *** msd_pkg.sv ***
// Purpose: shared constants for the mode/sync pin decoder
// Assumes: core clock of 40 MHz; times are given in ns and turned into cycles here
// Notes: timing figures without a printed value are plain defaults
package msd_pkg;

    // ==================================================================
    // clock and time conversion
    localparam int CLK_MHZ = 40;

    // least time: round up, never below one cycle
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : ceil_cyc

    // longest time: round down, never below one cycle
    function automatic int floor_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : floor_cyc

    // ==================================================================
    // timing (ns as written, cycles derived)
    localparam int MODE_SETTLE_NS = 250000;
    localparam int SYNC_MIN_PERIOD_NS = 150;
    localparam int SYNC_MAX_PERIOD_NS = 5000;
    localparam int SYNC_MIN_PHASE_NS = 50;
    localparam int DEFAULT_SW_PERIOD_NS = 2500;
    localparam int MODE_SETTLE_CYC = ceil_cyc(MODE_SETTLE_NS);
    localparam int SYNC_MIN_PERIOD_CYC = ceil_cyc(SYNC_MIN_PERIOD_NS);
    localparam int SYNC_MAX_PERIOD_CYC = floor_cyc(SYNC_MAX_PERIOD_NS);
    localparam int SYNC_MIN_PHASE_CYC = ceil_cyc(SYNC_MIN_PHASE_NS);
    localparam int DEFAULT_SW_PERIOD_CYC = floor_cyc(DEFAULT_SW_PERIOD_NS);

    // ==================================================================
    // counts and widths
    localparam int CNT_W = 16;
    localparam int SETTLE_W = 24;
    localparam int PULSE_W = 12;
    localparam logic [PULSE_W-1:0] PULSE_CTRL_PULSES = 12'h0004;
    localparam logic [PULSE_W-1:0] LOCK_PULSES = 12'h0800;
    localparam logic [2:0] DOUBLE_PULSE_RISES = 3'h2;

    // ==================================================================
    // level classes from the pin comparators
    typedef enum logic [1:0] {
        LVL_GND   = 2'h0,
        LVL_VCC   = 2'h1,
        LVL_VIN   = 2'h3,
        LVL_STRAP = 2'h2
    } msd_level_e;

endpackage : msd_pkg
